// ==== rtl/enc_index_event.v ====
// Encoder index event configuration, position reload and capture with APB access
`timescale 1ns/1ps
`include "enc_index_regs.vh"
module enc_index_event #(
   parameter PW = 32
) (
   input  wire          pclk,
   input  wire          presetn,
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [11:0]   paddr,
   input  wire [31:0]   pwdata,
   output reg  [31:0]   prdata,
   output wire          pready,
   output wire          pslverr,
   input  wire          enc_a,
   input  wire          enc_b,
   input  wire          enc_n,
   input  wire [PW-1:0] actual_motor_position,
   output wire [PW-1:0] encoder_position,
   output wire          enc_const_decimal,
   output wire          index_event
);
   reg  [31:0]   encoder_input_config_reg;
   reg  [31:0]   enc_reset_val_reg;
   reg  [31:0]   enc_const_reg;
   reg  [PW-1:0] enc_pos_reg;
   reg  [PW-1:0] enc_latch_reg;
   reg  [PW-1:0] x_latch_reg;
   reg  [1:0]    step_reg;
   reg  [7:0]    event_count_reg;
   reg           latched_flag_reg;
   reg  [PW-1:0] enc_pos_next;
   reg  [1:0]    step_next;
   wire [2:0]    ab_n_sync;
   wire          wr_en;
   wire          rd_en;
   wire          act;
   wire          quad_inc;
   wire          quad_dec;
   wire          cfg_wr;

   function addr_hit;
      input [11:0] a;
      input [11:0] target;
      begin
         addr_hit = (a[11:2] == target[11:2]);
      end
   endfunction

   function [31:0] widen;
      input [PW-1:0] v;
      reg   [PW+31:0] ext;
      begin
         ext   = {{32{v[PW-1]}}, v};
         widen = ext[31:0];
      end
   endfunction

   input_sync #(
      .W (3)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({enc_n, enc_b, enc_a}),
      .q       (ab_n_sync)
   );

   index_qualify u_qual (
      .pclk               (pclk),
      .presetn            (presetn),
      .n_sync             (ab_n_sync[2]),
      .a_sync             (ab_n_sync[0]),
      .b_sync             (ab_n_sync[1]),
      .pol_n              (encoder_input_config_reg[`B_POL_N]),
      .index_trigger_type (encoder_input_config_reg[`B_SENS_HI:`B_SENS_LO]),
      .pol_a              (encoder_input_config_reg[`B_POL_A]),
      .pol_b              (encoder_input_config_reg[`B_POL_B]),
      .skip_phase_gating  (encoder_input_config_reg[`B_SKIP_AB]),
      .index_event        (index_event)
   );

   // Zero-wait APB slave; unmapped addresses answer with pslverr
   assign pready = 1'b1;
   assign wr_en  = psel & penable & pwrite;
   assign rd_en  = psel & penable & ~pwrite;
   assign cfg_wr = wr_en & addr_hit(paddr, `INPUT_CFG_ADDR);

   function mapped;
      input [11:0] a;
      begin
         mapped = addr_hit(a, `INPUT_CFG_ADDR) | addr_hit(a, `ENC_RESET_VAL_ADDR) |
                  addr_hit(a, `ENC_POS_ADDR) | addr_hit(a, `ENC_LATCH_ADDR) |
                  addr_hit(a, `X_LATCH_ADDR) | addr_hit(a, `ACT_POS_ADDR) |
                  addr_hit(a, `ENC_CONST_ADDR) | addr_hit(a, `STATUS_ADDR);
      end
   endfunction
   assign pslverr = psel & penable & ~mapped(paddr);

   // Action fires on every event in continuous mode or once when armed
   assign act = index_event & (encoder_input_config_reg[`B_CONT] |
                               encoder_input_config_reg[`B_ONCE]);

   // Simple x2 quadrature decode on both A edges, direction from B
   always @* begin
      step_next = ab_n_sync[1:0];
   end
   assign quad_inc = (step_reg[0] ^ ab_n_sync[0]) & (ab_n_sync[0] ^ ab_n_sync[1]);
   assign quad_dec = (step_reg[0] ^ ab_n_sync[0]) & ~(ab_n_sync[0] ^ ab_n_sync[1]);

   always @* begin
      enc_pos_next = enc_pos_reg;
      if (quad_inc)
         enc_pos_next = enc_pos_reg + {{(PW-1){1'b0}}, 1'b1};
      else if (quad_dec)
         enc_pos_next = enc_pos_reg - {{(PW-1){1'b0}}, 1'b1};
      // Reload has priority over counting in the event cycle
      if (act && encoder_input_config_reg[`B_CLEAR_ON_N])
         enc_pos_next = enc_reset_val_reg[PW-1:0];
      // A software write to the position wins over everything
      if (wr_en && addr_hit(paddr, `ENC_POS_ADDR))
         enc_pos_next = pwdata[PW-1:0];
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         encoder_input_config_reg <= `INPUT_CFG_RESET;
         enc_reset_val_reg        <= 32'h00000000;
         enc_const_reg            <= 32'h00000000;
         enc_pos_reg              <= {PW{1'b0}};
         enc_latch_reg            <= {PW{1'b0}};
         x_latch_reg              <= {PW{1'b0}};
         step_reg                 <= 2'h0;
         event_count_reg          <= 8'h00;
         latched_flag_reg         <= 1'b0;
      end else begin
         step_reg    <= step_next;
         enc_pos_reg <= enc_pos_next;
         if (cfg_wr)
            encoder_input_config_reg <= pwdata;
         // Hardware clearing of the one-shot bit beats a same-cycle write
         if (act && !encoder_input_config_reg[`B_CONT] &&
             encoder_input_config_reg[`B_ONCE])
            encoder_input_config_reg[`B_ONCE] <= 1'b0;
         if (wr_en && addr_hit(paddr, `ENC_RESET_VAL_ADDR))
            enc_reset_val_reg <= pwdata;
         if (wr_en && addr_hit(paddr, `ENC_CONST_ADDR))
            enc_const_reg <= pwdata;
         if (act && encoder_input_config_reg[`B_LATCH_ENC])
            enc_latch_reg <= enc_pos_reg;
         if (act && encoder_input_config_reg[`B_LATCH_X])
            x_latch_reg <= actual_motor_position;
         if (act)
            event_count_reg <= event_count_reg + 8'h01;
         // Sticky flag: set beats a read-clear in the same cycle; only a reported set is cleared
         if (act)
            latched_flag_reg <= 1'b1;
         else if (rd_en && addr_hit(paddr, `STATUS_ADDR) && prdata[0])
            latched_flag_reg <= 1'b0;
      end
   end

   // Decimal interpretation is carried out by the consumer of the constant
   assign enc_const_decimal = encoder_input_config_reg[`B_DECIMAL];
   assign encoder_position  = enc_pos_reg;

   function [31:0] read_word;
      input [11:0] a;
      begin
         read_word = 32'h00000000;
         if (addr_hit(a, `INPUT_CFG_ADDR))
            read_word = encoder_input_config_reg;
         else if (addr_hit(a, `ENC_RESET_VAL_ADDR))
            read_word = enc_reset_val_reg;
         else if (addr_hit(a, `ENC_POS_ADDR))
            read_word = widen(enc_pos_reg);
         else if (addr_hit(a, `ENC_LATCH_ADDR))
            read_word = widen(enc_latch_reg);
         else if (addr_hit(a, `X_LATCH_ADDR))
            read_word = widen(x_latch_reg);
         else if (addr_hit(a, `ACT_POS_ADDR))
            read_word = widen(actual_motor_position);
         else if (addr_hit(a, `ENC_CONST_ADDR))
            read_word = enc_const_reg;
         else if (addr_hit(a, `STATUS_ADDR))
            read_word = {20'h00000, event_count_reg, ab_n_sync, latched_flag_reg};
      end
   endfunction

   // Read data is loaded at the end of the setup phase and stands through the access phase;
   // it is one cycle old, the price of a flop output with zero wait states
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (psel && !penable && !pwrite)
         prdata <= read_word(paddr);
      else
         prdata <= 32'h00000000;
   end
endmodule // enc_index_event

// ==== rtl/enc_index_regs.vh ====
// Register offsets, field positions and reset values of the index event block
`ifndef ENC_INDEX_REGS_VH
`define ENC_INDEX_REGS_VH
`define INPUT_CFG_IDX          8'h07
`define INPUT_CFG_ADDR         12'h01C
`define INPUT_CFG_RESET        32'h00000400
`define ENC_RESET_VAL_ADDR     12'h020
`define ENC_POS_ADDR           12'h024
`define ENC_LATCH_ADDR         12'h028
`define X_LATCH_ADDR           12'h02C
`define ACT_POS_ADDR           12'h030
`define ENC_CONST_ADDR         12'h034
`define STATUS_ADDR            12'h038
`define B_DECIMAL              0
`define B_CLEAR_ON_N           1
`define B_CONT                 2
`define B_ONCE                 3
`define B_POL_N                4
`define B_SENS_LO              5
`define B_SENS_HI              6
`define B_POL_A                7
`define B_POL_B                8
`define B_SKIP_AB              9
`define B_LATCH_ENC            10
`define B_LATCH_X              11
`define SENS_LEVEL             2'h0
`define SENS_TO_ACTIVE         2'h1
`define SENS_TO_INACTIVE       2'h2
`define SENS_BOTH              2'h3
`endif

// ==== rtl/input_sync.v ====
// Two-flop synchroniser for a group of encoder inputs
`timescale 1ns/1ps
module input_sync #(
   parameter W = 3
) (
   input  wire         pclk,
   input  wire         presetn,
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] meta_reg;
   reg [W-1:0] sync_reg;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= {W{1'b0}};
         sync_reg <= {W{1'b0}};
      end else begin
         meta_reg <= d;
         sync_reg <= meta_reg;
      end
   end
   assign q = sync_reg;
endmodule // input_sync

// ==== rtl/index_qualify.v ====
// Index polarity, trigger type and A/B gating
`timescale 1ns/1ps
`include "enc_index_regs.vh"
module index_qualify (
   input  wire       pclk,
   input  wire       presetn,
   input  wire       n_sync,
   input  wire       a_sync,
   input  wire       b_sync,
   input  wire       pol_n,
   input  wire [1:0] index_trigger_type,
   input  wire       pol_a,
   input  wire       pol_b,
   input  wire       skip_phase_gating,
   output wire       index_event
);
   reg        n_prev_reg;
   reg  [1:0] warm_reg;
   reg        trig;
   wire       n_act;
   wire       n_edge;
   wire       ab_ok;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         n_prev_reg <= 1'b0;
         warm_reg   <= 2'h0;
      end else begin
         n_prev_reg <= n_sync;
         if (warm_reg != 2'h3)
            warm_reg <= warm_reg + 2'h1;
      end
   end

   // Edges stay masked until the sync chain and history flop hold real pin values;
   // otherwise an idle-high index line fakes an edge right after reset
   assign n_edge = (n_sync ^ n_prev_reg) & (warm_reg == 2'h3);

   // Polarity folded in after edge detection; the edge term uses the raw synchronised line
   assign n_act = n_sync ~^ pol_n;

   always @* begin
      case (index_trigger_type)
         `SENS_LEVEL:       trig = n_act;
         `SENS_TO_ACTIVE:   trig = n_edge & n_act;
         `SENS_TO_INACTIVE: trig = n_edge & ~n_act;
         `SENS_BOTH:        trig = n_edge;
         default:           trig = 1'b0;
      endcase
   end

   // Gating sampled in the same cycle as the trigger
   assign ab_ok = skip_phase_gating |
                  ((a_sync == pol_a) & (b_sync == pol_b));
   assign index_event = trig & ab_ok;
endmodule // index_qualify

// ==== testbench/enc_index_event_sva.sv ====
// Port assertions for the index event block
`timescale 1ns/1ps
module enc_index_event_sva #(
   parameter PW = 32
) (
   input wire          pclk,
   input wire          presetn,
   input wire          psel,
   input wire          penable,
   input wire          pwrite,
   input wire [11:0]   paddr,
   input wire [31:0]   pwdata,
   input wire [31:0]   prdata,
   input wire          pready,
   input wire          pslverr,
   input wire          enc_a,
   input wire          enc_b,
   input wire          enc_n,
   input wire [PW-1:0] actual_motor_position,
   input wire [PW-1:0] encoder_position,
   input wire          enc_const_decimal,
   input wire          index_event
);
   reg  [31:0] cfg_reg;
   reg  [31:0] rld_reg;
   reg  [2:0]  up_reg;
   wire        wr = psel && penable && pwrite;
   wire        d0 = pwdata[0];
   wire [1:0]  ty = cfg_reg[6:5];
   // Settle count restarts on a config write so edge history is never stale
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg <= 32'h00000400;
         rld_reg <= 32'h00000000;
         up_reg  <= 3'h0;
      end else begin
         if (wr && paddr == 12'h01C) cfg_reg <= pwdata;
         if (wr && paddr == 12'h020) rld_reg <= pwdata;
         up_reg <= (wr && paddr == 12'h01C) ? 3'h0 : up_reg + {2'h0, up_reg != 3'h7};
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   pready_high_a: assert property (pready) else $error("pready low");
   err_in_access_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
   decimal_flag_a: assert property (
      wr && paddr == 12'h01C |=> enc_const_decimal == $past(d0)) else $error("decimal flag");
   reload_pos_a: assert property (
      index_event && cfg_reg[1] && cfg_reg[2] && !wr |=> encoder_position == rld_reg)
      else $error("no reload");
   level_mode_a: assert property (
      cfg_reg[9] && ty == 2'h0 && up_reg == 3'h7 |-> index_event == ($past(enc_n, 2) == cfg_reg[4]))
      else $error("level event");
   to_active_a: assert property (
      index_event && cfg_reg[9] && ty == 2'h1 && up_reg == 3'h7
      |-> $past(enc_n, 2) == cfg_reg[4] && $past(enc_n, 3) != cfg_reg[4]) else $error("rise event");
   to_inactive_a: assert property (
      index_event && cfg_reg[9] && ty == 2'h2 && up_reg == 3'h7
      |-> $past(enc_n, 2) != cfg_reg[4] && $past(enc_n, 3) == cfg_reg[4]) else $error("fall event");
   both_edges_a: assert property (
      index_event && cfg_reg[9] && ty == 2'h3 && up_reg == 3'h7
      |-> $past(enc_n, 2) != $past(enc_n, 3)) else $error("edge event");
   ab_gating_a: assert property (
      index_event && !cfg_reg[9] && up_reg == 3'h7
      |-> $past(enc_a, 2) == cfg_reg[7] && $past(enc_b, 2) == cfg_reg[8]) else $error("gating");
endmodule // enc_index_event_sva
bind enc_index_event enc_index_event_sva #(.PW(PW)) chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b),
   .enc_n(enc_n), .actual_motor_position(actual_motor_position),
   .encoder_position(encoder_position), .enc_const_decimal(enc_const_decimal),
   .index_event(index_event));

// ==== testbench/encoder_model.sv ====
// Incremental encoder model driving channel and index lines
`timescale 1ns/1ps
module encoder_model (
   input  wire pclk,
   output reg  enc_a = 1'b0,
   output reg  enc_b = 1'b0,
   output reg  enc_n = 1'b1
);
   // Lines only move just after a rising edge, never mid-cycle
   task set_lines(input a, input b, input n);
      @(posedge pclk);
      enc_a <= a;
      enc_b <= b;
      enc_n <= n;
      repeat (4) @(posedge pclk);
   endtask
   task index_pulse(input act, input integer w);
      @(posedge pclk);
      enc_n <= act;
      repeat (w) @(posedge pclk);
      enc_n <= ~act;
   endtask
endmodule // encoder_model

// ==== testbench/encoder_index_event_config_tb_top.sv ====
// Self-checking bench for the index event block
`timescale 1ns/1ps
module encoder_index_event_config_tb_top;
   localparam [11:0] CFG = 12'h01C;
   localparam [31:0] RLD = 32'h12345678;
   localparam [31:0] AMP = 32'hCAFE0001;
   reg         pclk = 1'b0;
   reg         presetn = 1'b0;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [11:0] paddr = 12'h000;
   reg  [31:0] pwdata = 32'h00000000;
   wire [31:0] prdata;
   wire        pready;
   wire        pslverr;
   wire        enc_a;
   wire        enc_b;
   wire        enc_n;
   wire [31:0] encoder_position;
   wire        enc_const_decimal;
   wire        index_event;
   reg  [31:0] rd;
   reg         er;
   integer     cnt;
   integer     t;
   integer     bad_count = 0;
   integer     samples_checked = 0;
   always #12.5 pclk = ~pclk;
   encoder_model enc (.pclk(pclk), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n));
   enc_index_event #(.PW(32)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n),
      .actual_motor_position(AMP), .encoder_position(encoder_position),
      .enc_const_decimal(enc_const_decimal), .index_event(index_event));
   task chk(input [31:0] seen, input [31:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Counts qualified index cycles seen across one index pulse
   task pulse(input act, input integer w);
      fork
         enc.index_pulse(act, w);
         begin
            cnt = 0;
            repeat (w + 8) @(negedge pclk) cnt = cnt + index_event;
         end
      join
   endtask
   task regs_scn;
      apb(0, CFG, 0);
      chk(rd, 32'h00000400);
      apb(0, 12'hFFC, 0);
      chk(er, 1);
      apb(1, 12'h034, 32'h00000123);
      apb(0, 12'h034, 0);
      chk(rd, 32'h00000123);
      apb(0, 12'h030, 0);
      chk(rd, AMP);
      apb(1, CFG, 32'h00000201);
      @(negedge pclk);
      chk(enc_const_decimal, 1);
      apb(1, CFG, 32'h00000200);
      @(negedge pclk);
      chk(enc_const_decimal, 0);
   endtask
   task types_scn;
      enc.set_lines(0, 0, 1);
      for (t = 0; t < 4; t = t + 1) begin
         apb(1, CFG, 32'h00000200 | (t << 5));
         pulse(0, 4);
         chk(cnt, t == 0 ? 4 : (t == 3 ? 2 : 1));
      end
   endtask
   // Reload stays off during closed-loop use; this bench never closes the loop
   task reload_scn;
      enc.set_lines(0, 0, 0);
      apb(1, CFG, 32'h00000E36);
      apb(1, 12'h020, RLD);
      apb(1, 12'h024, 32'h00000011);
      pulse(1, 3);
      apb(0, 12'h024, 0);
      chk(rd, RLD);
      chk(encoder_position, RLD);
      apb(0, 12'h028, 0);
      chk(rd, 32'h00000011);
      apb(0, 12'h02C, 0);
      chk(rd, AMP);
      apb(1, CFG, 32'h0000023A);
      apb(1, 12'h024, 32'h00000005);
      pulse(1, 3);
      apb(0, 12'h024, 0);
      chk(rd, RLD);
      apb(0, CFG, 0);
      chk(rd, 32'h00000232);
      apb(1, 12'h024, 32'h00000077);
      pulse(1, 3);
      apb(0, 12'h024, 0);
      chk(rd, 32'h00000077);
      apb(1, CFG, 32'h00000234);
      pulse(1, 3);
      apb(0, 12'h024, 0);
      chk(rd, 32'h00000077);
   endtask
   // Position is rewritten after each line change since A edges also count
   task gate_scn(input a, input b, input [31:0] cfg, input [31:0] exp);
      enc.set_lines(a, b, 0);
      apb(1, CFG, cfg);
      apb(1, 12'h024, 32'h00000005);
      pulse(1, 3);
      apb(0, 12'h024, 0);
      chk(rd, exp);
   endtask
   task complete_run;
      $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #100000;
      bad_count = bad_count + 1;
      complete_run;
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      regs_scn;
      types_scn;
      reload_scn;
      gate_scn(0, 0, 32'h000000B6, 32'h00000005);
      gate_scn(1, 1, 32'h000000B6, 32'h00000005);
      gate_scn(1, 0, 32'h000000B6, RLD);
      gate_scn(0, 1, 32'h000002B6, RLD);
      complete_run;
   end
endmodule // encoder_index_event_config_tb_top
